//--- design/dtp_map.vh
`ifndef DTP_MAP_VH
`define DTP_MAP_VH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define DTP_IDX_FLAGS 10'h00B
`define DTP_IDX_PRESCALE 10'h210
`define DTP_IDX_A_CTRL 10'h211
`define DTP_IDX_A_LOW 10'h212
`define DTP_IDX_A_HIGH 10'h213
`define DTP_IDX_B_CTRL 10'h214
`define DTP_IDX_B_LOW 10'h215
`define DTP_IDX_B_HIGH 10'h216
`define DTP_IDX_START_A 10'h220
`define DTP_IDX_START_B 10'h221
`define DTP_IDX_EN_A 10'h224
`define DTP_IDX_EN_B 10'h225
`define DTP_IDX_CH0_LO 10'h226
`define DTP_IDX_CH0_HI 10'h227
`define DTP_IDX_CH1_LO 10'h229
`define DTP_IDX_CH1_HI 10'h22A
`define DTP_IDX_CH3_LO 10'h22F
`define DTP_IDX_CH3_HI 10'h230
`define DTP_IDX_CH4_LO 10'h232
`define DTP_IDX_CH4_HI 10'h233

// ****************************************************************
// Field positions.
// ****************************************************************
`define DTP_CTL_RUN 0
`define DTP_CTL_SRC_LO 1
`define DTP_CTL_SRC_HI 2
`define DTP_CTL_RELOAD 3
`define DTP_FLAG_A 1
`define DTP_FLAG_B 2
`define DTP_SRC_PRESCALED 2'b00
`define DTP_SRC_FAST_RC 2'b01
`define DTP_SRC_SLOW 2'b10
`define DTP_SRC_CHAIN 2'b11

// ****************************************************************
// Reset values and timing.
// ****************************************************************
`define DTP_RST_NIBBLE 4'h0
`define DTP_RST_BYTE 8'h00
`define DTP_CLK_HZ 20000000
`define DTP_SYS_FAST_HZ 4000000
`define DTP_SYS_DIV (`DTP_CLK_HZ / `DTP_SYS_FAST_HZ)

`endif

//--- design/dtp_timer_pwm.v
// Behaviour
// (R1) Two-bit source picks prescaled, fast RC, slow clock, or time-base/timer_a overflow.
// (R2) Data nibble writes fill the preload buffer; reads return the live counter.
// (R3) Writing run to one loads the complemented preload and starts counting.
// (R4) Counter counts up; at FF sets flag and reloads if auto-reload.
// (R5) Overflow rising edge sets the timer's interrupt flag.
// (R6) Eight-bit period is preload ticks, or 256 when preload is zero.
// (R7) Cascaded period is B*256+A ticks, or 65536 when both are zero.
// (R8) Software uses counter mode with auto-reload cleared, toggling run.
// (R9) Software stops the counter before reading it to avoid transients.
// (R10) Timer_b source 11 cascades both timers into one 16-bit timer.
// (R11) In cascade timer_a run starts and stops both, loading both halves.
// (R12) In cascade timer_b overflow reloads both halves when timer_b auto-reload set.
// (R13) In cascade timer_a overflow raises no flag; timer_b flags normally.
// (R14) PWM period comes from timer_b; pin driven only if enabled and output.
// (R15) Enabling a channel while timer_b runs waits for the next timer_b overflow.
// (R16) Duty high nibble written first; low nibble write transfers full duty.
// (R17) Output starts at start level, flips at duty compare, returns on overflow.
// (R18) Start-level bit zero starts low, one starts high.
// (R19) Software keeps every duty no larger than timer_b's preload.
// (R20) Software avoids PWM in cascade and a zero timer_b preload with PWM.
// (R21) Software does not run PWM channels in cascaded 16-bit mode.
// (R22) Four channels 0, 1, 3, 4 share timer_b's cycle, each own duty.
// (R23) Prescaled clock is 4 MHz divided by 1 to 128 by a 3-bit code.
// (R24) Timer_a control holds reload, two source bits and run, reset to zero.
// (R25) Interrupt flags clear only by writing zero; writing one does nothing.
// (R26) A stopped timer holds its count and ignores count clock edges.
// (R27) Slow and time-base sources are synchronised before use as count events.
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`include "dtp_map.vh"

module dtp_timer_pwm (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire fastRcClk,
    input wire slowClk,
    input wire timebaseOvf,
    input wire [3:0] pinIsOutput,
    output reg [3:0] pwmPinOutput,
    output wire [3:0] pwmPinDrive,
    output wire timerAIrq,
    output wire timerBIrq
);

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    localparam [31:0] SYS_DIV_LAST = `DTP_SYS_DIV - 1;

    wire [9:0] idx = paddr[11:2];
    wire wrAcc = psel & penable & pwrite;
    wire [3:0] wNib = pwdata[3:0];
    reg [3:0] rdNib;
    reg mapped;

    // The slave never stalls, so every access completes in its first access cycle.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ****************************************************************
    // Register state.
    // ****************************************************************
    reg [3:0] ctlA;
    reg [3:0] ctlB;
    reg [2:0] prescaleSel;
    reg [7:0] preA;
    reg [7:0] preB;
    reg [7:0] cntA;
    reg [7:0] cntB;
    reg flagA;
    reg flagB;
    reg [3:0] startLvl;
    reg [3:0] chanEn;
    reg [7:0] next_cntA;
    reg [7:0] next_cntB;
    reg [15:0] next16;
    reg ovfA;
    reg ovfB;
    wire [31:0] dutyBus;
    wire [31:0] holdBus;

    wire runA = ctlA[`DTP_CTL_RUN];
    wire runB = ctlB[`DTP_CTL_RUN];
    wire [1:0] srcA = ctlA[`DTP_CTL_SRC_HI:`DTP_CTL_SRC_LO];
    wire [1:0] srcB = ctlB[`DTP_CTL_SRC_HI:`DTP_CTL_SRC_LO];
    wire cascade = (srcB == `DTP_SRC_CHAIN); // R10
    wire timerBActive = cascade ? runA : runB;

    // ****************************************************************
    // Count event sources.
    // ****************************************************************
    reg [2:0] syncA;
    reg [2:0] syncB;
    reg [2:0] edgeQ;
    reg [2:0] fastDiv;
    reg [6:0] preCnt;

    // Two flops per pin input, then a third flop purely for edge detection.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 3'b000;
            syncB <= 3'b000;
            edgeQ <= 3'b000;
        end else begin
            syncA <= {timebaseOvf, slowClk, fastRcClk}; // R27
            syncB <= syncA;
            edgeQ <= syncB;
        end
    end

    wire rcTick = syncB[0] & ~edgeQ[0];
    wire slowTick = syncB[1] & ~edgeQ[1];
    wire tbTick = syncB[2] & ~edgeQ[2];

    // The 4 MHz system rate is an enable from clk; the prescaler divides that enable.
    wire sysTick = (fastDiv == SYS_DIV_LAST[2:0]);
    wire [7:0] preMask = (8'h01 << prescaleSel) - 8'h01;
    wire presTick = sysTick & ((preCnt & preMask[6:0]) == preMask[6:0]); // R23

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fastDiv <= 3'h0;
            preCnt <= 7'h00;
        end else begin
            fastDiv <= sysTick ? 3'h0 : fastDiv + 3'h1;
            if (sysTick) begin
                preCnt <= preCnt + 7'h01;
            end
        end
    end

    // Source select per timer; every tick is an argument, so the assignments below follow each source.
    function srcTick;
        input [1:0] sel;
        input pres, rc, slow, other;
        begin
            case (sel)
                `DTP_SRC_PRESCALED: srcTick = pres;
                `DTP_SRC_FAST_RC: srcTick = rc;
                `DTP_SRC_SLOW: srcTick = slow;
                default: srcTick = other;
            endcase
        end
    endfunction

    wire tickA = runA & srcTick(srcA, presTick, rcTick, slowTick, tbTick); // R1 R26
    wire tickB = runB & ~cascade & srcTick(srcB, presTick, rcTick, slowTick, 1'b0); // R1 R26

    // ****************************************************************
    // Counters.
    // ****************************************************************
    wire wrCtlA = wrAcc & (idx == `DTP_IDX_A_CTRL);
    wire wrCtlB = wrAcc & (idx == `DTP_IDX_B_CTRL);
    wire loadA = wrCtlA & wNib[`DTP_CTL_RUN] & ~runA; // R3
    wire loadB = (wrCtlB & wNib[`DTP_CTL_RUN] & ~runB & ~cascade) | (cascade & loadA); // R11

    // Reload uses the negated preload so the count lands on FF after exactly preload ticks.
    always @* begin
        next_cntA = cntA;
        next_cntB = cntB;
        next16 = {cntB, cntA};
        ovfA = 1'b0;
        ovfB = 1'b0;
        if (cascade) begin
            if (loadA) begin
                next16 = ~{preB, preA}; // R11
            end else if (tickA) begin
                if ({cntB, cntA} == 16'hFFFF) begin
                    next16 = ctlB[`DTP_CTL_RELOAD] ? 16'h0000 - {preB, preA} : 16'h0000; // R12 R7
                end else begin
                    next16 = {cntB, cntA} + 16'h0001;
                end
                ovfB = (next16 == 16'hFFFF);
            end
            next_cntA = next16[7:0];
            next_cntB = next16[15:8];
        end else begin
            if (loadA) begin
                next_cntA = ~preA; // R3
            end else if (tickA) begin
                if (cntA == 8'hFF) begin
                    next_cntA = ctlA[`DTP_CTL_RELOAD] ? 8'h00 - preA : 8'h00; // R4 R6
                end else begin
                    next_cntA = cntA + 8'h01; // R4
                end
                ovfA = (next_cntA == 8'hFF);
            end
            if (loadB) begin
                next_cntB = ~preB; // R3
            end else if (tickB) begin
                if (cntB == 8'hFF) begin
                    next_cntB = ctlB[`DTP_CTL_RELOAD] ? 8'h00 - preB : 8'h00; // R4 R6
                end else begin
                    next_cntB = cntB + 8'h01;
                end
                ovfB = (next_cntB == 8'hFF);
            end
        end
    end

    // Control, preload and counter registers.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctlA <= `DTP_RST_NIBBLE;
            ctlB <= `DTP_RST_NIBBLE;
            prescaleSel <= 3'b000;
            preA <= `DTP_RST_BYTE;
            preB <= `DTP_RST_BYTE;
            cntA <= `DTP_RST_BYTE;
            cntB <= `DTP_RST_BYTE;
        end else begin
            cntA <= next_cntA;
            cntB <= next_cntB;
            if (wrCtlA) begin
                ctlA <= wNib; // R24
            end
            if (wrCtlB) begin
                ctlB <= wNib;
            end
            if (wrAcc & (idx == `DTP_IDX_PRESCALE)) begin
                prescaleSel <= wNib[2:0];
            end
            if (wrAcc & (idx == `DTP_IDX_A_LOW)) begin
                preA[3:0] <= wNib; // R2
            end
            if (wrAcc & (idx == `DTP_IDX_A_HIGH)) begin
                preA[7:4] <= wNib; // R2
            end
            if (wrAcc & (idx == `DTP_IDX_B_LOW)) begin
                preB[3:0] <= wNib; // R2
            end
            if (wrAcc & (idx == `DTP_IDX_B_HIGH)) begin
                preB[7:4] <= wNib; // R2
            end
        end
    end

    // ****************************************************************
    // Interrupt flags.
    // ****************************************************************
    wire wrFlags = wrAcc & (idx == `DTP_IDX_FLAGS);

    // A flag raised in the same cycle as a clearing write stays set, so no event is lost.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flagA <= 1'b0;
            flagB <= 1'b0;
        end else begin
            if (ovfA & ~cascade) begin
                flagA <= 1'b1; // R5 R13
            end else if (wrFlags & ~pwdata[`DTP_FLAG_A]) begin
                flagA <= 1'b0; // R25
            end
            if (ovfB) begin
                flagB <= 1'b1; // R5 R13
            end else if (wrFlags & ~pwdata[`DTP_FLAG_B]) begin
                flagB <= 1'b0; // R25
            end
        end
    end

    assign timerAIrq = flagA;
    assign timerBIrq = flagB;

    // ****************************************************************
    // PWM channels.
    // ****************************************************************
    wire wrEnA = wrAcc & (idx == `DTP_IDX_EN_A);
    wire wrEnB = wrAcc & (idx == `DTP_IDX_EN_B);
    wire wrStA = wrAcc & (idx == `DTP_IDX_START_A);
    wire wrStB = wrAcc & (idx == `DTP_IDX_START_B);
    wire [3:0] chWrEn = {wrEnB, wrEnA, wrEnA, wrEnA};
    wire [3:0] chWrSt = {wrStB, wrStA, wrStA, wrStA};
    wire [3:0] chBit = {pwdata[0], pwdata[3], pwdata[1], pwdata[0]};
    wire pwmTick = tickB & ~cascade; // R14
    reg [3:0] effEn;
    reg [3:0] pending;

    assign pwmPinDrive = effEn & pinIsOutput; // R14

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : gCh
            localparam [9:0] LO_IDX = (i == 0) ? `DTP_IDX_CH0_LO : (i == 1) ? `DTP_IDX_CH1_LO :
                                      (i == 2) ? `DTP_IDX_CH3_LO : `DTP_IDX_CH4_LO;
            localparam [9:0] HI_IDX = (i == 0) ? `DTP_IDX_CH0_HI : (i == 1) ? `DTP_IDX_CH1_HI :
                                      (i == 2) ? `DTP_IDX_CH3_HI : `DTP_IDX_CH4_HI;
            reg [7:0] duty;
            reg [3:0] hold;

            assign dutyBus[8*i+7:8*i] = duty;
            assign holdBus[8*i+3:8*i] = hold;
            assign holdBus[8*i+7:8*i+4] = 4'h0;

            // Duty only changes on the low write, so a half-written value never reaches the compare.
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    duty <= `DTP_RST_BYTE;
                    hold <= `DTP_RST_NIBBLE;
                end else begin
                    if (wrAcc & (idx == HI_IDX)) begin
                        hold <= wNib; // R16
                    end
                    if (wrAcc & (idx == LO_IDX)) begin
                        duty <= {hold, wNib}; // R16 R22
                    end
                end
            end

            // Enable, deferred enable, start level and output level.
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    chanEn[i] <= 1'b0;
                    effEn[i] <= 1'b0;
                    pending[i] <= 1'b0;
                    startLvl[i] <= 1'b0;
                    pwmPinOutput[i] <= 1'b0;
                end else begin
                    if (chWrSt[i]) begin
                        startLvl[i] <= chBit[i]; // R18
                    end
                    if (chWrEn[i]) begin
                        chanEn[i] <= chBit[i];
                    end
                    if (chWrEn[i] & ~chBit[i]) begin
                        effEn[i] <= 1'b0;
                        pending[i] <= 1'b0;
                    end else if (chWrEn[i] & chBit[i] & ~chanEn[i]) begin
                        if (timerBActive) begin
                            pending[i] <= 1'b1; // R15
                        end else begin
                            effEn[i] <= 1'b1;
                        end
                    end else if (pending[i] & ovfB) begin
                        effEn[i] <= 1'b1; // R15
                        pending[i] <= 1'b0;
                    end
                    if (loadB | ~effEn[i]) begin
                        pwmPinOutput[i] <= startLvl[i]; // R17 R18
                    end else if (pwmTick) begin
                        pwmPinOutput[i] <= startLvl[i] ^ (next_cntB > ~duty); // R17 R22
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Read path.
    // ****************************************************************
    // Counter reads are live; a read during a count edge can catch a moving value.
    always @* begin
        rdNib = 4'h0;
        mapped = 1'b1;
        case (idx)
            `DTP_IDX_FLAGS: rdNib = {1'b0, flagB, flagA, 1'b0};
            `DTP_IDX_PRESCALE: rdNib = {1'b0, prescaleSel};
            `DTP_IDX_A_CTRL: rdNib = ctlA;
            `DTP_IDX_A_LOW: rdNib = cntA[3:0]; // R2
            `DTP_IDX_A_HIGH: rdNib = cntA[7:4]; // R2
            `DTP_IDX_B_CTRL: rdNib = ctlB;
            `DTP_IDX_B_LOW: rdNib = cntB[3:0]; // R2
            `DTP_IDX_B_HIGH: rdNib = cntB[7:4]; // R2
            `DTP_IDX_START_A: rdNib = {startLvl[2], 1'b0, startLvl[1], startLvl[0]};
            `DTP_IDX_START_B: rdNib = {3'b000, startLvl[3]};
            `DTP_IDX_EN_A: rdNib = {chanEn[2], 1'b0, chanEn[1], chanEn[0]};
            `DTP_IDX_EN_B: rdNib = {3'b000, chanEn[3]};
            `DTP_IDX_CH0_LO: rdNib = dutyBus[3:0];
            `DTP_IDX_CH0_HI: rdNib = holdBus[3:0];
            `DTP_IDX_CH1_LO: rdNib = dutyBus[11:8];
            `DTP_IDX_CH1_HI: rdNib = holdBus[11:8];
            `DTP_IDX_CH3_LO: rdNib = dutyBus[19:16];
            `DTP_IDX_CH3_HI: rdNib = holdBus[19:16];
            `DTP_IDX_CH4_LO: rdNib = dutyBus[27:24];
            `DTP_IDX_CH4_HI: rdNib = holdBus[27:24];
            default: mapped = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle and stays fixed through the access phase.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= {28'h000_0000, rdNib};
        end
    end

endmodule

//--- testbench/dtp_timer_pwm_sva.sv
`timescale 1ns/1ns
`include "dtp_map.vh"
// ****
// Port checker for the timer and PWM block.
// ****
module dtp_timer_pwm_sva (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire fastRcClk,
    input wire slowClk,
    input wire timebaseOvf,
    input wire [3:0] pinIsOutput,
    input wire [3:0] pwmPinOutput,
    input wire [3:0] pwmPinDrive,
    input wire timerAIrq,
    input wire timerBIrq
);
    logic [3:0] aCtrl, bCtrl, stA, stB, enA, enB;
    wire wrOk = psel && penable && pwrite;
    wire [9:0] idx = paddr[11:2];
    wire flagWr = wrOk && idx == `DTP_IDX_FLAGS;
    wire clrA = flagWr && !pwdata[`DTP_FLAG_A];
    wire clrB = flagWr && !pwdata[`DTP_FLAG_B];
    wire chain = bCtrl[2:1] == `DTP_SRC_CHAIN;
    wire aRun = aCtrl[0];
    wire bRun = bCtrl[0] || (chain && aCtrl[0]);
    wire [3:0] enV = {enB[0], enA[3], enA[1], enA[0]};
    wire [3:0] stV = {stB[0], stA[3], stA[1], stA[0]};
    wire [3:0] idle = pinIsOutput & ~pwmPinDrive;

    // Shadows rebuilt from bus writes alone, so a stuck design register cannot hide itself.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aCtrl <= 4'h0;
            bCtrl <= 4'h0;
            stA <= 4'h0;
            stB <= 4'h0;
            enA <= 4'h0;
            enB <= 4'h0;
        end else if (wrOk) begin
            case (idx)
                `DTP_IDX_A_CTRL: aCtrl <= pwdata[3:0];
                `DTP_IDX_B_CTRL: bCtrl <= pwdata[3:0];
                `DTP_IDX_START_A: stA <= pwdata[3:0];
                `DTP_IDX_START_B: stB <= pwdata[3:0];
                `DTP_IDX_EN_A: enA <= pwdata[3:0];
                `DTP_IDX_EN_B: enB <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_DRIVE_PIN: assert property ((pwmPinDrive & ~pinIsOutput) == 4'h0)
        else $error("pin driven while set as input");
    AST_DRIVE_EN: assert property ((pwmPinDrive & ~enV) == 4'h0)
        else $error("pin driven by a disabled channel");
    AST_START_LVL: assert property ($stable(stV) |-> ((pwmPinOutput ^ stV) & idle & $past(idle)) == 4'h0)
        else $error("idle channel away from its start level");
    AST_A_CLR: assert property ($fell(timerAIrq) |-> $past(clrA))
        else $error("timer a flag dropped without a zero write");
    AST_B_CLR: assert property ($fell(timerBIrq) |-> $past(clrB))
        else $error("timer b flag dropped without a zero write");
    AST_A_RUN: assert property ($rose(timerAIrq) |-> $past(aRun))
        else $error("timer a flag set while stopped");
    AST_A_CHAIN: assert property ($rose(timerAIrq) |-> !$past(chain))
        else $error("timer a flag set in cascade");
    AST_B_RUN: assert property ($rose(timerBIrq) |-> $past(bRun))
        else $error("timer b flag set while stopped");
    AST_MAPPED: assert property (psel && penable && idx == `DTP_IDX_A_CTRL |-> pready && !pslverr)
        else $error("control access refused");
endmodule

bind dtp_timer_pwm dtp_timer_pwm_sva i_sva (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fastRcClk(fastRcClk), .slowClk(slowClk), .timebaseOvf(timebaseOvf), .pinIsOutput(pinIsOutput),
    .pwmPinOutput(pwmPinOutput), .pwmPinDrive(pwmPinDrive), .timerAIrq(timerAIrq), .timerBIrq(timerBIrq));

//--- testbench/dtp_timer_pwm_tb.sv
`timescale 1ns/1ns
`include "dtp_map.vh"
`define DTP_CHK(g, x) begin comparisons++; if ((g) !== (x)) begin nMismatch++; $display("Error at %0t: got %h expected %h", $time, g, x); end end
module dtp_timer_pwm_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic fastRcClk = 1'b0;
    logic slowClk = 1'b0;
    logic timebaseOvf = 1'b0;
    logic [3:0] pinIsOutput = 4'hF;
    wire [31:0] prdata;
    wire pready, pslverr, timerAIrq, timerBIrq;
    wire [3:0] pwmPinOutput, pwmPinDrive;
    int nMismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    int n;
    logic [3:0] d, expV;
    logic e;
    logic [7:0] cnt;
    logic [7:0] duty [4] = '{8'h02, 8'h04, 8'h01, 8'h00};
    logic [9:0] loIdx [4] = '{`DTP_IDX_CH0_LO, `DTP_IDX_CH1_LO, `DTP_IDX_CH3_LO, `DTP_IDX_CH4_LO};
    logic [9:0] hiIdx [4] = '{`DTP_IDX_CH0_HI, `DTP_IDX_CH1_HI, `DTP_IDX_CH3_HI, `DTP_IDX_CH4_HI};
    logic [9:0] ctl [8] = '{`DTP_IDX_A_CTRL, `DTP_IDX_B_CTRL, `DTP_IDX_START_A, `DTP_IDX_START_B,
        `DTP_IDX_EN_A, `DTP_IDX_EN_B, `DTP_IDX_FLAGS, `DTP_IDX_PRESCALE};

    dtp_timer_pwm i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fastRcClk(fastRcClk), .slowClk(slowClk), .timebaseOvf(timebaseOvf), .pinIsOutput(pinIsOutput),
        .pwmPinOutput(pwmPinOutput), .pwmPinDrive(pwmPinDrive), .timerAIrq(timerAIrq), .timerBIrq(timerBIrq));

    always #25 clk = ~clk;

    // Guard against a hang; the ceiling is well above the planned run.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            nMismatch++;
            conclude();
        end
    end

    task conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One bus transfer; the answer is taken at the edge where pready is seen high.
    task xfer(input logic wr, input logic [9:0] idx, input logic [3:0] v);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {28'h000_0000, v};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        d = prdata[3:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task rd(input logic [9:0] idx, input logic [3:0] x);
        xfer(1'b0, idx, 4'h0);
        `DTP_CHK(d, x)
    endtask

    // Source edges stay four cycles high and low, slower than the synchroniser needs.
    task tick(input int src, input int k);
        repeat (k) begin
            @(posedge clk);
            fastRcClk <= (src == 1);
            slowClk <= (src == 2);
            timebaseOvf <= (src == 3);
            repeat (4) @(posedge clk);
            fastRcClk <= 1'b0;
            slowClk <= 1'b0;
            timebaseOvf <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    task waitA;
        n = 0;
        while (timerAIrq !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(ctl[i], 4'h0);
        xfer(1'b0, 10'h100, 4'h0);
        `DTP_CHK({e, d}, 5'h10)
        xfer(1'b1, `DTP_IDX_A_CTRL, 4'hE);
        rd(`DTP_IDX_A_CTRL, 4'hE);
        xfer(1'b1, `DTP_IDX_A_LOW, 4'h3);
        rd(`DTP_IDX_A_LOW, 4'h0);
        // Every external source counts; edges while stopped are ignored.
        for (int s = 1; s < 4; s++) begin
            xfer(1'b1, `DTP_IDX_A_CTRL, {1'b1, s[1:0], 1'b1});
            tick(s, 2);
            xfer(1'b1, `DTP_IDX_A_CTRL, {1'b1, s[1:0], 1'b0});
            tick(s, 1);
            rd(`DTP_IDX_A_LOW, 4'hE);
            rd(`DTP_IDX_A_HIGH, 4'hF);
            xfer(1'b1, `DTP_IDX_A_CTRL, {1'b1, s[1:0], 1'b1});
            tick(s, 3);
            `DTP_CHK(timerAIrq, 1'b1)
            tick(s, 1);
            xfer(1'b1, `DTP_IDX_A_CTRL, {1'b1, s[1:0], 1'b0});
            rd(`DTP_IDX_A_LOW, 4'hD);
            xfer(1'b1, `DTP_IDX_FLAGS, 4'hF);
            `DTP_CHK(timerAIrq, 1'b1)
            xfer(1'b1, `DTP_IDX_FLAGS, 4'h0);
            `DTP_CHK(timerAIrq, 1'b0)
        end
        // Flag-to-flag period for each prescale code, the last pass with a zero preload.
        for (int s = 0; s < 9; s++) begin
            xfer(1'b1, `DTP_IDX_PRESCALE, s[3:0] & 4'h7);
            xfer(1'b1, `DTP_IDX_A_LOW, (s < 8) ? 4'h8 : 4'h0);
            xfer(1'b1, `DTP_IDX_A_CTRL, 4'h9);
            waitA;
            xfer(1'b1, `DTP_IDX_FLAGS, 4'h0);
            waitA;
            `DTP_CHK(n + 3, ((s < 8) ? 8 : 256) * (5 << (s & 7)))
            xfer(1'b1, `DTP_IDX_A_CTRL, 4'h8);
            xfer(1'b1, `DTP_IDX_FLAGS, 4'h0);
        end
        // Cascade of 0x0102 with reload; only the upper half may flag.
        xfer(1'b1, `DTP_IDX_B_CTRL, 4'hE);
        xfer(1'b1, `DTP_IDX_A_LOW, 4'h2);
        xfer(1'b1, `DTP_IDX_B_LOW, 4'h1);
        xfer(1'b1, `DTP_IDX_A_CTRL, 4'h3);
        tick(1, 257);
        `DTP_CHK(timerBIrq, 1'b0)
        tick(1, 2);
        `DTP_CHK({timerBIrq, timerAIrq}, 2'b10)
        xfer(1'b1, `DTP_IDX_A_CTRL, 4'h2);
        rd(`DTP_IDX_A_LOW, 4'hE);
        rd(`DTP_IDX_B_HIGH, 4'hF);
        xfer(1'b1, `DTP_IDX_B_CTRL, 4'hA);
        xfer(1'b1, `DTP_IDX_FLAGS, 4'h0);
        // Four channels on a period of four events.
        xfer(1'b1, `DTP_IDX_B_LOW, 4'h4);
        xfer(1'b1, `DTP_IDX_START_A, 4'h8);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, hiIdx[i], duty[i][7:4]);
            xfer(1'b1, loIdx[i], duty[i][3:0]);
            rd(loIdx[i], duty[i][3:0]);
        end
        xfer(1'b1, `DTP_IDX_EN_A, 4'hB);
        xfer(1'b1, `DTP_IDX_EN_B, 4'h1);
        #100;
        `DTP_CHK({pwmPinDrive, pwmPinOutput}, 8'hF4)
        @(posedge clk);
        pinIsOutput <= 4'hE;
        #100;
        `DTP_CHK(pwmPinDrive, 4'hE)
        @(posedge clk);
        pinIsOutput <= 4'hF;
        xfer(1'b1, `DTP_IDX_B_CTRL, 4'hB);
        cnt = 8'hFB;
        repeat (10) begin
            tick(1, 1);
            cnt = (cnt == 8'hFF) ? 8'hFC : cnt + 8'h01;
            for (int i = 0; i < 4; i++) expV[i] = (i == 2) ^ (cnt > ~duty[i]);
            `DTP_CHK(pwmPinOutput, expV)
        end
        xfer(1'b1, `DTP_IDX_EN_A, 4'h9);
        `DTP_CHK(pwmPinDrive[1], 1'b0)
        xfer(1'b1, `DTP_IDX_EN_A, 4'hB);
        tick(1, 1);
        `DTP_CHK(pwmPinDrive[1], 1'b0)
        tick(1, 1);
        `DTP_CHK(pwmPinDrive[1], 1'b1)
        conclude();
    end
endmodule
